/* inc/hms_pkg.sv */
package hms_pkg;

    // ==========================================================
    // Register indices (byte address = 4 * index)
    // ==========================================================
    localparam logic [7:0] IDX_CONFIG      = 8'h40;
    localparam logic [7:0] IDX_STAT_LOW    = 8'h41;
    localparam logic [7:0] IDX_STAT_HIGH   = 8'h42;
    localparam logic [7:0] IDX_VID         = 8'h47;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'h50;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'h51;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CFG_START_BIT = 0;
    localparam int CFG_FIXED_BIT = 3;
    localparam int CFG_RESET_BIT = 4;
    localparam int CFG_SEL12_BIT = 5;
    localparam int CFG_INIT_BIT  = 7;
    localparam int VID_SEL_BIT   = 7;
    localparam int VID_PIN_W     = 4;
    localparam int LOW_ERR_W     = 7;
    localparam int HIGH_ERR_W    = 4;
    localparam int FAULT_COND_W  = 7;
    localparam int IRQ_W         = 16;

    // ==========================================================
    // Reset values and read masks
    // ==========================================================
    localparam logic [7:0]  CFG_RESET_VAL   = 8'h08;
    localparam logic [7:0]  STAT_RESET_VAL  = 8'h00;
    localparam logic [7:0]  STAT_LOW_MASK   = 8'h7F;
    localparam logic [7:0]  STAT_HIGH_MASK  = 8'hCF;
    localparam logic [15:0] IRQ_RESET_VAL   = 16'h0000;
    localparam logic [31:0] RDATA_RESET_VAL = 32'h0000_0000;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ           = 40_000_000;
    localparam int RST_PULSE_MS     = 20;
    localparam int RST_PULSE_CYCLES = RST_PULSE_MS * (CLK_HZ / 1000);
    localparam int PULSE_CNT_W      = 20;

    typedef enum logic [1:0] {
        HMS_PULSE_IDLE = 2'b01,
        HMS_PULSE_LOW  = 2'b10
    } hms_pulse_state_t;

endpackage

/* logic/hms_pulse_timer.sv */
module hms_pulse_timer
    import hms_pkg::*;
#(
    parameter int CYCLES = RST_PULSE_CYCLES
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic start,
    output logic      active
);

    // ==========================================================
    // One-shot low-pulse timer
    // ==========================================================
    // A start during a running pulse is ignored; the pulse never shortens.
    localparam logic [PULSE_CNT_W-1:0] LAST = PULSE_CNT_W'(CYCLES - 1);

    hms_pulse_state_t       state_ff;
    hms_pulse_state_t       nxt_state;
    logic [PULSE_CNT_W-1:0] cnt_ff;
    logic [PULSE_CNT_W-1:0] nxt_cnt;
    wire  logic             cnt_done = (cnt_ff == LAST);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            HMS_PULSE_IDLE: begin
                nxt_cnt = '0;
                if (start) begin
                    nxt_state = HMS_PULSE_LOW;
                end
            end
            HMS_PULSE_LOW: begin
                nxt_cnt = cnt_ff + PULSE_CNT_W'(1);
                if (cnt_done) begin
                    nxt_state = HMS_PULSE_IDLE;
                    nxt_cnt   = '0;
                end
            end
            default: begin
                nxt_state = HMS_PULSE_IDLE;
                nxt_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= HMS_PULSE_IDLE;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign active = (state_ff == HMS_PULSE_LOW);

endmodule

/* logic/hms_status_regs.sv */
// What this block does
// - Remote diode 1 limit sets low status bit5.
// - Remote diode 2 limit sets bit6; bit7 reserved.
// - High status bits0-3 flag voltage limits; 5:4 reserved.
// - First diode pair fault sets high bit6.
// - Second diode pair fault sets high bit7.
// - Any open or short condition raises fault.
// - High status read-only, zero after reset/init.
// - Voltage-id bits 3:0 show pins; 6:4 reserved.
// - Voltage-id bit7 selects reset output or address.
// - Bit7 clear passes pin as address LSB.
// - Reset bit plus enable gives 20 ms low.
// - Init bit restores status defaults, self-clears.
module hms_status_regs
    import hms_pkg::*;
#(
    parameter int PULSE_CYCLES = RST_PULSE_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic                    hready,
    input  wire logic [31:0]             hwdata,
    output logic [31:0]                  hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire logic [LOW_ERR_W-1:0]    low_err_strobe,
    input  wire logic [HIGH_ERR_W-1:0]   high_err_strobe,
    input  wire logic [FAULT_COND_W-1:0] first_diode_fault_cond,
    input  wire logic [FAULT_COND_W-1:0] second_diode_fault_cond,
    input  wire logic [VID_PIN_W-1:0]    voltage_id_inputs,
    input  wire logic                    shared_pin_in,
    output logic                         reset_pulse_output,
    output logic                         shared_pin_oe_n,
    output logic                         slave_address_lsb,
    output logic                         monitor_start,
    output logic                         twelve_volt_sel,
    output logic                         irq
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    localparam int SYNC_W = 2 * FAULT_COND_W + VID_PIN_W + 1;

    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    wire  logic [SYNC_W-1:0] pins_raw = {first_diode_fault_cond, second_diode_fault_cond,
                                         voltage_id_inputs, shared_pin_in};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
        end
    end

    wire logic [FAULT_COND_W-1:0] first_cond_s  = sync2_ff[SYNC_W-1 -: FAULT_COND_W];
    wire logic [FAULT_COND_W-1:0] second_cond_s = sync2_ff[VID_PIN_W+1 +: FAULT_COND_W];
    wire logic [VID_PIN_W-1:0]    vid_pins_s    = sync2_ff[1 +: VID_PIN_W];
    wire logic                    shared_pin_s  = sync2_ff[0];

    // ==========================================================
    // AHB-Lite slave
    // ==========================================================
    // Zero wait states: read data is captured in the address phase, so a read
    // issued right behind a write to the same register returns the old value.
    wire logic       xfer_ok  = hsel & htrans[1] & hready;
    wire logic [7:0] a_idx    = haddr[9:2];
    wire logic       a_high0  = (haddr[31:10] == 22'h00_0000);
    wire logic       rd_start = xfer_ok & ~hwrite;
    wire logic       wr_start = xfer_ok & hwrite;

    logic       wr_pend_ff;
    logic [7:0] wr_idx_ff;
    logic       wr_in_map_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_ff   <= 1'b0;
            wr_idx_ff    <= 8'h00;
            wr_in_map_ff <= 1'b0;
        end else if (hready) begin
            wr_pend_ff   <= wr_start;
            wr_idx_ff    <= a_idx;
            wr_in_map_ff <= a_high0;
        end
    end

    wire logic       wr_go  = wr_pend_ff & wr_in_map_ff;
    wire logic [7:0] wd     = hwdata[7:0];
    wire logic       wr_cfg = wr_go & (wr_idx_ff == IDX_CONFIG);
    wire logic       wr_vid = wr_go & (wr_idx_ff == IDX_VID);
    wire logic       wr_irs = wr_go & (wr_idx_ff == IDX_IRQ_STATUS);
    wire logic       wr_irm = wr_go & (wr_idx_ff == IDX_IRQ_MASK);

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ==========================================================
    // Configuration: start, 12 V select, reset and init strobes
    // ==========================================================
    logic cfg_start_ff;
    logic cfg_sel12_ff;

    wire logic init_req  = wr_cfg & wd[CFG_INIT_BIT];
    wire logic reset_req = wr_cfg & wd[CFG_RESET_BIT] & ~wd[CFG_INIT_BIT];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_start_ff <= CFG_RESET_VAL[CFG_START_BIT];
            cfg_sel12_ff <= CFG_RESET_VAL[CFG_SEL12_BIT];
        end else if (init_req) begin
            cfg_start_ff <= CFG_RESET_VAL[CFG_START_BIT];
            cfg_sel12_ff <= CFG_RESET_VAL[CFG_SEL12_BIT];
        end else if (wr_cfg) begin
            cfg_start_ff <= wd[CFG_START_BIT];
            cfg_sel12_ff <= wd[CFG_SEL12_BIT];
        end
    end

    // Reset and init bits are strobes, never stored, so they read back as zero.
    wire logic [7:0] cfg_rd = {1'b0, 1'b0, cfg_sel12_ff, 1'b0,
                               CFG_RESET_VAL[CFG_FIXED_BIT], 2'b00, cfg_start_ff};

    assign monitor_start   = cfg_start_ff;
    assign twelve_volt_sel = cfg_sel12_ff;

    // ==========================================================
    // Sticky limit and fault status
    // ==========================================================
    wire logic first_fault  = |first_cond_s;
    wire logic second_fault = |second_cond_s;

    wire logic [7:0] low_set  = {1'b0, low_err_strobe};
    wire logic [7:0] high_set = {second_fault, first_fault, 2'b00, high_err_strobe};

    logic [7:0] stat_low_ff;
    logic [7:0] stat_high_ff;

    // A new error in the init cycle survives: setting beats clearing.
    wire logic [7:0] nxt_stat_low  = ((init_req ? STAT_RESET_VAL : stat_low_ff) | low_set) & STAT_LOW_MASK;
    wire logic [7:0] nxt_stat_high = ((init_req ? STAT_RESET_VAL : stat_high_ff) | high_set) & STAT_HIGH_MASK;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_low_ff  <= STAT_RESET_VAL;
            stat_high_ff <= STAT_RESET_VAL;
        end else begin
            stat_low_ff  <= nxt_stat_low;
            stat_high_ff <= nxt_stat_high;
        end
    end

    // ==========================================================
    // Voltage-id register and shared pin
    // ==========================================================
    logic vid_sel_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vid_sel_ff <= 1'b0;
        end else if (init_req) begin
            vid_sel_ff <= 1'b0;
        end else if (wr_vid) begin
            vid_sel_ff <= wd[VID_SEL_BIT];
        end
    end

    wire logic [7:0] vid_rd = {vid_sel_ff, 3'b000, vid_pins_s};

    logic pulse_active;

    // A reset request while the output function is off is dropped, not queued.
    hms_pulse_timer #(
        .CYCLES (PULSE_CYCLES)
    ) u_pulse (
        .clk    (clk),
        .arst_n (arst_n),
        .start  (reset_req & vid_sel_ff),
        .active (pulse_active)
    );

    // The output is held low only while the pin is in reset-output mode.
    assign reset_pulse_output = ~(pulse_active & vid_sel_ff);
    assign shared_pin_oe_n    = ~vid_sel_ff;
    assign slave_address_lsb  = vid_sel_ff ? 1'b0 : shared_pin_s;

    // ==========================================================
    // Interrupt status and mask
    // ==========================================================
    // Only a fresh rise of a status bit is an event, so a standing fault
    // does not re-raise the interrupt once software has cleared it.
    wire logic [IRQ_W-1:0] evt = {high_set & ~stat_high_ff & STAT_HIGH_MASK,
                                  low_set & ~stat_low_ff & STAT_LOW_MASK};

    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_mask_ff;

    wire logic [IRQ_W-1:0] irq_clr      = wr_irs ? hwdata[IRQ_W-1:0] : '0;
    wire logic [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | evt;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_ff <= IRQ_RESET_VAL;
            irq_mask_ff <= IRQ_RESET_VAL;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_irm) begin
                irq_mask_ff <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // The interrupt line leaves a flop fed from the next state, so it shows no
    // decode glitch and still rises in the same cycle as its status bit.
    wire logic [IRQ_W-1:0] nxt_irq_mask = wr_irm ? hwdata[IRQ_W-1:0] : irq_mask_ff;
    wire logic             nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
    logic                  irq_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign irq = irq_ff;

    // ==========================================================
    // Read multiplexer
    // ==========================================================
    wire logic        hit_cfg = (a_idx == IDX_CONFIG);
    wire logic        hit_sl  = (a_idx == IDX_STAT_LOW);
    wire logic        hit_sh  = (a_idx == IDX_STAT_HIGH);
    wire logic        hit_vid = (a_idx == IDX_VID);
    wire logic        hit_irs = (a_idx == IDX_IRQ_STATUS);
    wire logic        hit_irm = (a_idx == IDX_IRQ_MASK);

    // Unmapped addresses read as zero with an OKAY response.
    wire logic [31:0] rd_mux =
        !a_high0 ? 32'h0000_0000 :
        hit_cfg  ? {24'h00_0000, cfg_rd} :
        hit_sl   ? {24'h00_0000, stat_low_ff} :
        hit_sh   ? {24'h00_0000, stat_high_ff} :
        hit_vid  ? {24'h00_0000, vid_rd} :
        hit_irs  ? {16'h0000, irq_stat_ff} :
        hit_irm  ? {16'h0000, irq_mask_ff} :
                   32'h0000_0000;

    logic [31:0] rdata_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= RDATA_RESET_VAL;
        end else if (rd_start) begin
            rdata_ff <= rd_mux;
        end
    end

    assign hrdata = rdata_ff;

endmodule

/* verification/hms_status_regs_monitor.sv */
// ==========================================================
// Port checker for the status, voltage-id and reset-pin logic
// ==========================================================
module hms_status_regs_monitor
    import hms_pkg::*;
#(
    parameter int PULSE_CYCLES = 16
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        shared_pin_in,
    input wire logic        reset_pulse_output,
    input wire logic        shared_pin_oe_n,
    input wire logic        slave_address_lsb,
    input wire logic        monitor_start
);
    // Data-phase tracking: taken, write, unmapped, index.
    logic [10:0] ph_ff;
    logic [19:0] low_cnt_ff;
    wire  [10:0] nxt_ph      = {hsel && htrans[1] && hready, hwrite, |haddr[31:10], haddr[9:2]};
    wire  [19:0] nxt_low_cnt = reset_pulse_output ? 20'h0 : low_cnt_ff + 20'h1;
    wire         ph_rd       = ph_ff[10] && !ph_ff[9];
    wire         ph_wr_cfg   = ph_ff[10] && ph_ff[9] && ph_ff[8:0] == {1'b0, IDX_CONFIG};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_ff <= 11'h000;
            low_cnt_ff <= 20'h0;
        end else begin
            ph_ff <= nxt_ph;
            low_cnt_ff <= nxt_low_cnt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("Bus answer is not ready with OKAY");
    a_low_reserved: assert property (ph_rd && ph_ff[8:0] == {1'b0, IDX_STAT_LOW} |-> hrdata[31:7] == 25'h0)
        else $error("Reserved low status bits read nonzero");
    a_high_reserved: assert property (ph_rd && ph_ff[8:0] == {1'b0, IDX_STAT_HIGH}
        |-> hrdata[31:8] == 24'h0 && hrdata[5:4] == 2'h0) else $error("Reserved high status bits read nonzero");
    a_vid_reserved: assert property (ph_rd && ph_ff[8:0] == {1'b0, IDX_VID}
        |-> hrdata[31:8] == 24'h0 && hrdata[6:4] == 3'h0) else $error("Reserved voltage-id bits read nonzero");
    a_unmapped_zero: assert property (ph_rd && ph_ff[8] |-> hrdata == 32'h0)
        else $error("Unmapped read returned data");
    a_pulse_needs_sel: assert property (!reset_pulse_output |-> !shared_pin_oe_n)
        else $error("Reset pulse while pin is an input");
    a_addr_masked: assert property (!shared_pin_oe_n |-> !slave_address_lsb)
        else $error("Address bit passed while pin drives reset");
    a_addr_follow: assert property ((shared_pin_oe_n && $stable(shared_pin_in))[*3]
        |-> slave_address_lsb == shared_pin_in) else $error("Address bit does not follow pin");
    a_pulse_start: assert property (ph_wr_cfg && hwdata[4] && !hwdata[7] && !shared_pin_oe_n
        && reset_pulse_output |=> !reset_pulse_output) else $error("Reset pulse did not start");
    a_pulse_length: assert property ($rose(reset_pulse_output) && !shared_pin_oe_n
        |-> low_cnt_ff == PULSE_CYCLES) else $error("Reset pulse length wrong");
    a_init_release: assert property (ph_wr_cfg && hwdata[7] |=> shared_pin_oe_n && !monitor_start)
        else $error("Initialization left settings in place");
endmodule

/* verification/tb_top.sv */
// ==========================================================
// Bench: register traffic, event strobes and pin checks
// ==========================================================
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int P = 16;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [6:0]  low_err = 7'h00;
    logic [3:0]  high_err = 4'h0;
    logic [6:0]  fault1 = 7'h00;
    logic [6:0]  fault2 = 7'h00;
    logic [3:0]  vid = 4'hA;
    logic        pin_in = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, rst_out, oe_n, addr_lsb, mon_start, sel12, irq;
    wire  logic  hready = hreadyout;
    int          errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          n;

    always #12.5 clk = ~clk;

    hms_status_regs #(.PULSE_CYCLES(P)) uut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .low_err_strobe(low_err), .high_err_strobe(high_err),
        .first_diode_fault_cond(fault1), .second_diode_fault_cond(fault2), .voltage_id_inputs(vid),
        .shared_pin_in(pin_in), .reset_pulse_output(rst_out), .shared_pin_oe_n(oe_n),
        .slave_address_lsb(addr_lsb), .monitor_start(mon_start), .twelve_volt_sel(sel12), .irq(irq));

    task automatic end_sim();
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Address phase waits for hready, then the data phase waits again.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask

    // Counts low cycles of the reset pin over a window longer than one pulse.
    task automatic count_low(input int span);
        n = 0;
        repeat (span) begin
            @(negedge clk);
            if (rst_out !== 1'b1)
                n++;
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("Error at %0t: run did not finish", $time);
            end_sim();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rd(32'h100, 32'h08);
        rd(32'h108, 32'h00);
        rd(32'h11C, 32'h0A);
        rd(32'h400, 32'h00);
        wr(32'h108, 32'hFF);
        rd(32'h108, 32'h00);
        wr(32'h11C, 32'h75);
        rd(32'h11C, 32'h0A);
        @(posedge clk);
        low_err <= 7'h60;
        @(posedge clk);
        low_err <= 7'h00;
        rd(32'h104, 32'h60);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            high_err <= 4'h1 << i;
            @(posedge clk);
            high_err <= 4'h0;
            rd(32'h108, (2 << i) - 1);
        end
        // Each condition line alone must raise its diode's fault.
        for (int j = 0; j < 7; j++) begin
            wr(32'h100, 32'h80);
            rd(32'h108, 32'h00);
            @(posedge clk);
            fault1 <= 7'h01 << j;
            fault2 <= 7'h40 >> j;
            repeat (4) @(posedge clk);
            fault1 <= 7'h00;
            fault2 <= 7'h00;
            rd(32'h108, 32'hC0);
        end
        // Every status rise so far has left its event bit; clear them before the mask tests.
        rd(32'h140, 32'hCF60);
        wr(32'h140, 32'hFFFF);
        wr(32'h144, 32'h0100);
        @(posedge clk);
        high_err <= 4'h1;
        @(posedge clk);
        high_err <= 4'h0;
        repeat (2) @(negedge clk);
        check({31'h0, irq}, 32'h1);
        wr(32'h140, 32'h0100);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        wr(32'h144, 32'h0000);
        @(posedge clk);
        high_err <= 4'h2;
        @(posedge clk);
        high_err <= 4'h0;
        repeat (2) @(negedge clk);
        check({31'h0, irq}, 32'h0);
        rd(32'h140, 32'h0200);
        wr(32'h144, 32'h0200);
        @(negedge clk);
        check({31'h0, irq}, 32'h1);
        wr(32'h140, 32'h0200);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        // A reset request while the pin is an input must be dropped.
        wr(32'h100, 32'h10);
        count_low(P + 4);
        check(n, 0);
        wr(32'h11C, 32'h80);
        rd(32'h11C, 32'h8A);
        @(negedge clk);
        check({30'h0, oe_n, addr_lsb}, 32'h0);
        wr(32'h100, 32'h10);
        count_low(P + 8);
        check(n, P);
        rd(32'h100, 32'h08);
        wr(32'h11C, 32'h00);
        @(posedge clk);
        pin_in <= 1'b1;
        repeat (4) @(negedge clk);
        check({30'h0, oe_n, addr_lsb}, 32'h3);
        wr(32'h100, 32'h21);
        rd(32'h100, 32'h29);
        @(negedge clk);
        check({30'h0, mon_start, sel12}, 32'h3);
        // A reset in mid-run must clear the sticky high status bits.
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(32'h108, 32'h00);
        wr(32'h100, 32'h21);
        wr(32'h11C, 32'h80);
        @(negedge clk);
        check({30'h0, oe_n, addr_lsb}, 32'h0);
        wr(32'h100, 32'h80);
        rd(32'h100, 32'h08);
        rd(32'h11C, 32'h0A);
        end_sim();
    end
endmodule

bind hms_status_regs hms_status_regs_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) u_mon (.clk(clk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .shared_pin_in(shared_pin_in),
    .reset_pulse_output(reset_pulse_output), .shared_pin_oe_n(shared_pin_oe_n),
    .slave_address_lsb(slave_address_lsb), .monitor_start(monitor_start));
